// file: core/vfr_pkg.sv
// Constants shared by the output voltage fault action block.
package vfr_pkg;
  // Command codes of the two fault action commands.
  localparam logic [7:0] VFR_CMD_OV        = 8'h41;
  localparam logic [7:0] VFR_CMD_UV        = 8'h45;
  // Reset value of both commands and the field layout.
  localparam logic [7:0] VFR_ACTION_RESET  = 8'hbf;
  localparam int         VFR_RSP_BIT       = 7;
  localparam int         VFR_ZERO_BIT      = 6;
  localparam int         VFR_RETRY_MSB     = 5;
  localparam int         VFR_RETRY_LSB     = 3;
  localparam int         VFR_DELAY_MSB     = 2;
  localparam int         VFR_DELAY_LSB     = 0;
  localparam logic [2:0] VFR_RETRY_NONE    = 3'h0;
  localparam logic [2:0] VFR_RETRY_ALWAYS  = 3'h7;
  // Restart waits this many output rise times.
  localparam int         VFR_DELAY_RISES   = 7;
  // Clock period and default output rise time.
  localparam int         VFR_CLK_PERIOD_NS = 40;
  localparam int         VFR_RISE_TIME_NS  = 1000000;
  localparam int         VFR_RISE_CYCLES   = (VFR_RISE_TIME_NS + VFR_CLK_PERIOD_NS - 1) / VFR_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    VFR_ST_RUN,
    VFR_ST_LATCHED,
    VFR_ST_DELAY
  } vfr_state_t;
endpackage

// file: core/vfr_fault_action.sv
// Output overvoltage and undervoltage fault action commands with restart sequencing.
//
// Functional notes
// - Overvoltage sets its flags and alert.
// - Undervoltage sets its flags and alert.
// - Faults detected against percent limits.
// - Loop slave: ignore, NACK, invalid command, alert.
// - Both commands reset to 10111111.
// - Select 0: keep running, flags still set.
// - Select 1: shut down, then retry setting.
// - Retry 000: stay off until cleared.
// - Retry 111: restart without limit.
// - Retry codes other than 000/111 rejected.
// - Only bit 5 of retry is stored.
// - Store-all copies both commands to memory.
// - Delay 111 waits seven rise times.
// - Delay 000 means no restart.
// - Delay bits mirror bit 5.
// - Rejected write sets invalid data flag.
`timescale 1ns/1ns
module vfr_fault_action
  import vfr_pkg::*;
#(
  parameter int RISE_CYCLES = VFR_RISE_CYCLES // Output rise time in clock cycles.
)
(
  input  wire logic       i_clk,                   // 25 MHz clock.
  input  wire logic       i_rst_n,                 // Asynchronous reset, active low.
  input  wire logic       i_cmd_valid,             // Command transfer strobe.
  input  wire logic       i_cmd_read,              // High for read, low for write.
  input  wire logic [7:0] i_cmd_code,              // Command code.
  input  wire logic [7:0] i_cmd_wdata,             // Write data byte.
  output logic            o_cmd_ack,               // Command accepted.
  output logic            o_cmd_nack,              // Command refused.
  output logic      [7:0] o_cmd_rdata,             // Read data byte.
  input  wire logic       i_loop_slave,            // Device is the loop slave.
  input  wire logic [7:0] i_vout_pct,              // Output voltage in percent of nominal.
  input  wire logic [7:0] i_ov_limit_pct,          // Overvoltage fault limit, percent.
  input  wire logic [7:0] i_uv_limit_pct,          // Undervoltage fault limit, percent.
  input  wire logic       i_on,                    // Output commanded on.
  input  wire logic       i_clear_faults,          // Clear all fault flags.
  input  wire logic       i_alert_mask,            // Masks this block's alert source.
  input  wire logic       i_store_all,             // Store defaults to memory.
  input  wire logic       i_nvm_restore,           // Restore from memory.
  input  wire logic [1:0] i_nvm_ov_bits,           // Stored {select, retry} for overvoltage.
  input  wire logic [1:0] i_nvm_uv_bits,           // Stored {select, retry} for undervoltage.
  output logic            o_nvm_we,                // Memory write strobe.
  output logic      [1:0] o_nvm_ov_bits,           // {select, retry} to store, overvoltage.
  output logic      [1:0] o_nvm_uv_bits,           // {select, retry} to store, undervoltage.
  output logic            o_output_enable,         // Power stage enable.
  output logic            o_restart,               // Soft-start restart pulse.
  output logic            o_ov_flag,               // Status byte overvoltage flag.
  output logic            o_other_flag,            // Status byte summary flag.
  output logic            o_vout_summary_flag,     // Status word output voltage flag.
  output logic            o_vout_ov_flag,          // Output voltage status overvoltage.
  output logic            o_vout_uv_flag,          // Output voltage status undervoltage.
  output logic            o_cml_flag,              // Status byte communication flag.
  output logic            o_invalid_data_flag,     // Communication status invalid data.
  output logic            o_invalid_command_fault, // Communication status invalid command.
  output logic            o_smbalert_out,          // Alert pin level when driven.
  output logic            o_smbalert_oe            // Alert pin drive enable.
);

  localparam int DELAY_CYCLES = VFR_DELAY_RISES * RISE_CYCLES;
  localparam int CNT_W        = $clog2(DELAY_CYCLES + 1);
  localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_CYCLES - 1);
  localparam logic [7:0] CMD_CODE [2] = '{VFR_CMD_OV, VFR_CMD_UV};

  if (RISE_CYCLES < 1)
  begin : g_bad_rise
    $error("RISE_CYCLES must be at least one");
  end

  function automatic logic retry_ok(input logic [2:0] code);
    retry_ok = (code == VFR_RETRY_NONE) || (code == VFR_RETRY_ALWAYS);
  endfunction

  function automatic logic [7:0] readback(input logic rsp, input logic rs);
    logic [7:0] v;
    v = '0;
    v[VFR_RSP_BIT] = rsp;
    v[VFR_ZERO_BIT] = 1'b0;
    v[VFR_RETRY_MSB:VFR_RETRY_LSB] = {3{rs}};
    v[VFR_DELAY_MSB:VFR_DELAY_LSB] = {3{rs}};
    readback = v;
  endfunction

  logic [1:0]       rsp_reg;   // Index 0 overvoltage, 1 undervoltage.
  logic [1:0]       rs_reg;
  logic [1:0]       hit;
  logic             any_hit;
  logic             bad_write;
  logic             ov_now;
  logic             uv_now;
  logic             shut_req;
  logic             retry_now;
  vfr_state_t       state_reg;
  vfr_state_t       state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic             seen_reg;

  assign ov_now = i_vout_pct > i_ov_limit_pct;
  assign uv_now = i_vout_pct < i_uv_limit_pct;
  assign any_hit = |hit;
  assign bad_write = any_hit && !i_cmd_read && !i_loop_slave
                     && !retry_ok(i_cmd_wdata[VFR_RETRY_MSB:VFR_RETRY_LSB]);

  // Only the select bit and one retry bit are kept; the other retry bits and
  // the delay bits are rebuilt from it, which is why a mixed code cannot be held.
  genvar k;
  generate
    for (k = 0; k < 2; k++)
    begin : g_cmd
      assign hit[k] = i_cmd_valid && (i_cmd_code == CMD_CODE[k]);

      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          rsp_reg[k] <= VFR_ACTION_RESET[VFR_RSP_BIT];
          rs_reg[k]  <= VFR_ACTION_RESET[VFR_RETRY_MSB];
        end
        else if (i_nvm_restore)
        begin
          rsp_reg[k] <= (k == 0) ? i_nvm_ov_bits[1] : i_nvm_uv_bits[1];
          rs_reg[k]  <= (k == 0) ? i_nvm_ov_bits[0] : i_nvm_uv_bits[0];
        end
        else if (hit[k] && !i_cmd_read && !i_loop_slave
                 && retry_ok(i_cmd_wdata[VFR_RETRY_MSB:VFR_RETRY_LSB]))
        begin
          rsp_reg[k] <= i_cmd_wdata[VFR_RSP_BIT];
          rs_reg[k]  <= i_cmd_wdata[VFR_RETRY_MSB];
        end
      end
    end
  endgenerate

  // Command answer, one cycle after the strobe.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cmd_ack   <= 1'b0;
      o_cmd_nack  <= 1'b0;
      o_cmd_rdata <= 8'h00;
    end
    else
    begin
      o_cmd_ack  <= any_hit && !i_loop_slave;
      o_cmd_nack <= any_hit && i_loop_slave;
      if (any_hit && i_cmd_read && !i_loop_slave)
        o_cmd_rdata <= hit[0] ? readback(rsp_reg[0], rs_reg[0])
                              : readback(rsp_reg[1], rs_reg[1]);
    end
  end

  // Store-all copies the reduced form of both commands.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_nvm_we      <= 1'b0;
      o_nvm_ov_bits <= 2'h0;
      o_nvm_uv_bits <= 2'h0;
    end
    else
    begin
      o_nvm_we <= i_store_all;
      if (i_store_all)
      begin
        o_nvm_ov_bits <= {rsp_reg[0], rs_reg[0]};
        o_nvm_uv_bits <= {rsp_reg[1], rs_reg[1]};
      end
    end
  end

  // Sticky status flags; a fault present in the clearing cycle wins.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ov_flag               <= 1'b0;
      o_other_flag            <= 1'b0;
      o_vout_summary_flag     <= 1'b0;
      o_vout_ov_flag          <= 1'b0;
      o_vout_uv_flag          <= 1'b0;
      o_cml_flag              <= 1'b0;
      o_invalid_data_flag     <= 1'b0;
      o_invalid_command_fault <= 1'b0;
    end
    else
    begin
      o_ov_flag               <= ov_now | (o_ov_flag & ~i_clear_faults);
      o_vout_ov_flag          <= ov_now | (o_vout_ov_flag & ~i_clear_faults);
      o_other_flag            <= uv_now | (o_other_flag & ~i_clear_faults);
      o_vout_uv_flag          <= uv_now | (o_vout_uv_flag & ~i_clear_faults);
      o_vout_summary_flag     <= ov_now | uv_now | (o_vout_summary_flag & ~i_clear_faults);
      o_invalid_command_fault <= (any_hit & i_loop_slave)
                                 | (o_invalid_command_fault & ~i_clear_faults);
      o_invalid_data_flag     <= bad_write | (o_invalid_data_flag & ~i_clear_faults);
      o_cml_flag              <= bad_write | (any_hit & i_loop_slave)
                                 | (o_cml_flag & ~i_clear_faults);
    end
  end

  // Open-drain alert: pulled low while any flag stands and the source is not masked.
  assign o_smbalert_out = 1'b0;
  assign o_smbalert_oe = !i_alert_mask && (o_ov_flag | o_other_flag | o_vout_summary_flag | o_cml_flag
                         | o_invalid_data_flag | o_invalid_command_fault);

  // A fault shuts down only under a set select bit; retry continues only if
  // every shutting command allows it, so a latching fault overrides a retrying one.
  assign shut_req  = (ov_now && rsp_reg[0]) || (uv_now && rsp_reg[1]);
  assign retry_now = (!ov_now || !rsp_reg[0] || rs_reg[0])
                     && (!uv_now || !rsp_reg[1] || rs_reg[1]);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      VFR_ST_RUN:
        if (i_on && shut_req)
          state_next = retry_now ? VFR_ST_DELAY : VFR_ST_LATCHED;
      VFR_ST_LATCHED:
        if (i_clear_faults)
          state_next = VFR_ST_RUN;
      VFR_ST_DELAY:
        if (!i_on)
          state_next = VFR_ST_RUN;
        else if (cnt_reg == DELAY_LAST)
          state_next = VFR_ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_reg <= VFR_ST_RUN;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_reg <= '0;
    else if (state_reg == VFR_ST_DELAY && cnt_reg != DELAY_LAST)
      cnt_reg <= cnt_reg + CNT_W'(1);
    else
      cnt_reg <= '0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_output_enable <= 1'b0;
      o_restart       <= 1'b0;
    end
    else
    begin
      o_output_enable <= (state_next == VFR_ST_RUN) && i_on;
      o_restart       <= (state_reg == VFR_ST_DELAY) && i_on && (cnt_reg == DELAY_LAST);
    end
  end

  // Marks the first clock edge after reset release, for checking defaults.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      seen_reg <= 1'b0;
    else
      seen_reg <= 1'b1;
  end

  AST_OV_FLAGS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ov_now |=> (o_ov_flag && o_vout_summary_flag && o_vout_ov_flag))
    else $error("overvoltage did not set its flags");

  AST_UV_FLAGS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    uv_now |=> (o_other_flag && o_vout_summary_flag && o_vout_uv_flag))
    else $error("undervoltage did not set its flags");

  AST_LIMIT_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_clear_faults && i_vout_pct <= i_ov_limit_pct && i_vout_pct >= i_uv_limit_pct)
    |=> (!o_vout_ov_flag && !o_vout_uv_flag))
    else $error("voltage flag set inside percent limits");

  AST_SLAVE_NACK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (any_hit && i_loop_slave && !i_nvm_restore)
    |=> (o_cmd_nack && !o_cmd_ack && o_invalid_command_fault && $stable(rsp_reg) && $stable(rs_reg)))
    else $error("loop slave access not refused");

  AST_RESET_DEFAULT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !seen_reg |-> (rsp_reg == 2'h3 && rs_reg == 2'h3 && state_reg == VFR_ST_RUN))
    else $error("fault action reset value wrong");

  AST_IGNORE_RUNS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == VFR_ST_RUN && i_on && ov_now && !rsp_reg[0] && !(uv_now && rsp_reg[1]))
    |=> (state_reg == VFR_ST_RUN))
    else $error("ignored fault stopped the output");

  AST_SHUTDOWN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == VFR_ST_RUN && i_on && ov_now && rsp_reg[0]) |=> !o_output_enable [*2])
    else $error("output not shut down on fault");

  AST_LATCH_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == VFR_ST_LATCHED && !i_clear_faults) |=> (state_reg == VFR_ST_LATCHED && !o_output_enable))
    else $error("latched fault left the off state");

  AST_RESTART_ABANDON: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == VFR_ST_DELAY && !i_on) |=> (state_reg == VFR_ST_RUN && !o_restart))
    else $error("restart not abandoned when commanded off");

  AST_NO_RESTART: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == VFR_ST_LATCHED) |=> !o_restart)
    else $error("restart while latched off");

  AST_BAD_RETRY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bad_write && !i_nvm_restore)
    |=> ($stable(rsp_reg) && $stable(rs_reg) && o_invalid_data_flag && o_cml_flag && o_cmd_ack))
    else $error("bad retry code not rejected");

  AST_DELAY_LEN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_restart |-> ($past(cnt_reg) == DELAY_LAST && $past(state_reg) == VFR_ST_DELAY))
    else $error("restart delay length wrong");

  AST_NVM_STORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_store_all |=> (o_nvm_we && o_nvm_ov_bits == $past({rsp_reg[0], rs_reg[0]})
                     && o_nvm_uv_bits == $past({rsp_reg[1], rs_reg[1]})))
    else $error("store did not copy settings");

  AST_READBACK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (any_hit && i_cmd_read && !i_loop_slave)
    |=> (o_cmd_rdata[2:0] == o_cmd_rdata[5:3] && !o_cmd_rdata[6]
         && o_cmd_rdata[5] == $past(hit[0] ? rs_reg[0] : rs_reg[1])))
    else $error("readback layout wrong");

endmodule // vfr_fault_action

// file: test/vfr_host_model.sv
// Host controller model that issues byte commands to the fault action block.
`timescale 1ns/1ns
module vfr_host_model
(
  input  wire logic       i_clk,   // Block clock.
  input  wire logic       i_ack,   // Command accepted.
  input  wire logic       i_nack,  // Command refused.
  input  wire logic [7:0] i_rdata, // Read data.
  output logic            o_valid, // Command strobe.
  output logic            o_read,  // High for read.
  output logic      [7:0] o_code,  // Command code.
  output logic      [7:0] o_wdata  // Write byte.
);
  initial
  begin
    o_valid = 1'b0;
    o_read  = 1'b0;
    o_code  = 8'h00;
    o_wdata = 8'h00;
  end

  // One transfer; the answer is sampled one cycle after the request is driven, half a cycle after the block takes it.
  task automatic xfer(input logic rd, input logic [7:0] code, input logic [7:0] wd,
                      output logic ak, output logic nk, output logic [7:0] rdv);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_read  = rd;
    o_code  = code;
    o_wdata = wd;
    @(negedge i_clk);
    ak      = i_ack;
    nk      = i_nack;
    rdv     = i_rdata;
    o_valid = 1'b0;
    // Released data lines must not keep showing the last byte.
    o_wdata = ~wd;
  endtask
endmodule // vfr_host_model

// file: test/tb_top.sv
// Self-checking testbench for the output voltage fault action block.
`timescale 1ns/1ns
module tb_top
  import vfr_pkg::*;
;
  localparam int RC = 2;
  logic       i_clk, i_rst_n, i_cmd_valid, i_cmd_read, o_cmd_ack, o_cmd_nack;
  logic [7:0] i_cmd_code, i_cmd_wdata, o_cmd_rdata, i_vout_pct, i_ov_limit_pct, i_uv_limit_pct;
  logic       i_loop_slave, i_on, i_clear_faults, i_alert_mask, i_store_all, i_nvm_restore;
  logic [1:0] i_nvm_ov_bits, i_nvm_uv_bits, o_nvm_ov_bits, o_nvm_uv_bits;
  logic       o_nvm_we, o_output_enable, o_restart, o_ov_flag, o_other_flag, o_vout_summary_flag;
  logic       o_vout_ov_flag, o_vout_uv_flag, o_cml_flag, o_invalid_data_flag;
  logic       o_invalid_command_fault, o_smbalert_out, o_smbalert_oe, ak, nk;
  logic [7:0] rd;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         n;

  vfr_fault_action #(.RISE_CYCLES(RC)) dut_u
  (
    .i_clk, .i_rst_n, .i_cmd_valid, .i_cmd_read, .i_cmd_code, .i_cmd_wdata, .o_cmd_ack, .o_cmd_nack,
    .o_cmd_rdata, .i_loop_slave, .i_vout_pct, .i_ov_limit_pct, .i_uv_limit_pct, .i_on, .i_clear_faults,
    .i_alert_mask, .i_store_all, .i_nvm_restore, .i_nvm_ov_bits, .i_nvm_uv_bits, .o_nvm_we,
    .o_nvm_ov_bits, .o_nvm_uv_bits, .o_output_enable, .o_restart, .o_ov_flag, .o_other_flag,
    .o_vout_summary_flag, .o_vout_ov_flag, .o_vout_uv_flag, .o_cml_flag, .o_invalid_data_flag,
    .o_invalid_command_fault, .o_smbalert_out, .o_smbalert_oe
  );

  vfr_host_model host_u
  (
    .i_clk   (i_clk),
    .i_ack   (o_cmd_ack),
    .i_nack  (o_cmd_nack),
    .i_rdata (o_cmd_rdata),
    .o_valid (i_cmd_valid),
    .o_read  (i_cmd_read),
    .o_code  (i_cmd_code),
    .o_wdata (i_cmd_wdata)
  );

  always #20 i_clk = ~i_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("compares=%0d errors=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic rw(input logic r, input logic [7:0] c, input logic [7:0] w);
    host_u.xfer(r, c, w, ak, nk, rd);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask

  // Flags packed as {ov, other, summary, vout_ov, vout_uv, cml, invalid data, invalid command}.
  task automatic flags(input logic [7:0] exp);
    chk({o_ov_flag, o_other_flag, o_vout_summary_flag, o_vout_ov_flag, o_vout_uv_flag,
         o_cml_flag, o_invalid_data_flag, o_invalid_command_fault}, exp);
  endtask

  task automatic clr;
    i_clear_faults = 1'b1;
    cyc(1);
    i_clear_faults = 1'b0;
    cyc(1);
  endtask

  initial
  begin
    {i_clk, i_rst_n, i_loop_slave, i_on, i_clear_faults, i_alert_mask, i_store_all, i_nvm_restore} = 8'h00;
    {i_nvm_ov_bits, i_nvm_uv_bits} = 4'h0;
    i_vout_pct     = 8'h64;
    i_ov_limit_pct = 8'h6e;
    i_uv_limit_pct = 8'h5a;
    cyc(3);
    i_rst_n = 1'b1;
    rw(1'b1, VFR_CMD_OV, 8'h00); chk(rd, VFR_ACTION_RESET);
    rw(1'b1, VFR_CMD_UV, 8'h00); chk(rd, VFR_ACTION_RESET);
    rw(1'b0, VFR_CMD_UV, 8'hc7); chk({6'h00, ak, nk}, 8'h02);
    rw(1'b1, VFR_CMD_UV, 8'h00); chk(rd, 8'h80);
    rw(1'b0, VFR_CMD_OV, 8'h3f);
    rw(1'b1, VFR_CMD_OV, 8'h00); chk(rd, 8'h3f);
    $display("test fields done");
    // Retry code 101 is outside the two legal codes, so it must bounce.
    rw(1'b0, VFR_CMD_OV, 8'hab); chk({6'h00, ak, nk}, 8'h02);
    cyc(1);
    flags(8'h06);
    chk({6'h00, o_smbalert_out, o_smbalert_oe}, 8'h01);
    rw(1'b1, VFR_CMD_OV, 8'h00); chk(rd, 8'h3f);
    clr;
    flags(8'h00);
    $display("test reject done");
    i_loop_slave = 1'b1;
    rw(1'b0, VFR_CMD_UV, 8'hbf); chk({6'h00, ak, nk}, 8'h01);
    rw(1'b1, VFR_CMD_OV, 8'h00); chk({6'h00, ak, nk}, 8'h01);
    cyc(1);
    flags(8'h05);
    chk({7'h00, o_smbalert_oe}, 8'h01);
    i_loop_slave = 1'b0;
    clr;
    rw(1'b1, VFR_CMD_UV, 8'h00); chk(rd, 8'h80);
    $display("test loop slave done");
    i_store_all = 1'b1;
    cyc(1);
    i_store_all = 1'b0;
    chk({3'h0, o_nvm_we, o_nvm_ov_bits, o_nvm_uv_bits}, 8'h16);
    cyc(1);
    chk({7'h00, o_nvm_we}, 8'h00);
    {i_nvm_ov_bits, i_nvm_uv_bits} = 4'b1001;
    i_nvm_restore = 1'b1;
    cyc(1);
    i_nvm_restore = 1'b0;
    rw(1'b1, VFR_CMD_OV, 8'h00); chk(rd, 8'h80);
    rw(1'b1, VFR_CMD_UV, 8'h00); chk(rd, 8'h3f);
    rw(1'b0, VFR_CMD_OV, 8'h3f);
    rw(1'b0, VFR_CMD_UV, 8'h80);
    $display("test memory done");
    i_on = 1'b1;
    i_vout_pct = 8'h6e;
    cyc(3);
    chk({7'h00, o_output_enable}, 8'h01);
    flags(8'h00);
    i_vout_pct = 8'h6f;
    cyc(2);
    flags(8'hb0);
    chk({o_smbalert_oe, o_output_enable}, 8'h03);
    i_alert_mask = 1'b1;
    cyc(1);
    chk({7'h00, o_smbalert_oe}, 8'h00);
    i_alert_mask = 1'b0;
    i_vout_pct = 8'h64;
    clr;
    flags(8'h00);
    $display("test ignore done");
    i_vout_pct = 8'h59;
    cyc(1);
    i_vout_pct = 8'h64;
    cyc(1);
    flags(8'h68);
    cyc(7 * RC + 4);
    chk({o_restart, o_output_enable}, 8'h00);
    i_clear_faults = 1'b1;
    cyc(1);
    i_clear_faults = 1'b0;
    cyc(1);
    chk({7'h00, o_output_enable}, 8'h01);
    $display("test latch done");
    rw(1'b0, VFR_CMD_OV, 8'hbf);
    i_vout_pct = 8'h70;
    cyc(1);
    i_vout_pct = 8'h64;
    n = 1;
    chk({7'h00, o_output_enable}, 8'h00);
    while (o_restart !== 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    if (n >= 100)
    begin
      num_errors++;
      $display("[ERR] t=%0t restart wait timed out got=%h exp=%h", $time, n, 1 + VFR_DELAY_RISES * RC);
    end
    else
    begin
      chk(8'(n), 8'(1 + VFR_DELAY_RISES * RC));
      chk({7'h00, o_output_enable}, 8'h01);
    end
    $display("test restart done");
    // Dropping the on command inside the delay must abandon the restart.
    i_vout_pct = 8'h70;
    cyc(1);
    i_vout_pct = 8'h64;
    i_on = 1'b0;
    cyc(7 * RC);
    chk({o_restart, o_output_enable}, 8'h00);
    $display("test abandon done");
    results;
  end
endmodule // tb_top
